// *** sec_lock_pkg.sv ***
// Constants, field layouts and carriers for the drive security-lock block.
// Assumes a task-file front end that hands over opcodes and data words
// already synchronised to the drive's internal clock.
package sec_lock_pkg;

  // ----------------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_FREEZE_LOCK  = 8'hF5;
  localparam logic [7:0] OP_SET_PASSWORD = 8'hF1;
  localparam logic [7:0] OP_UNLOCK       = 8'hF2;
  localparam logic [7:0] OP_DISABLE_PW   = 8'hF6;
  localparam logic [7:0] OP_ERASE_UNIT   = 8'hF4;

  // ----------------------------------------------------------------------
  // Status and error bit positions
  // ----------------------------------------------------------------------
  localparam int BIT_BUSY    = 7;
  localparam int BIT_READY   = 6;
  localparam int BIT_XFER    = 3;
  localparam int BIT_ERR     = 0;
  localparam int BIT_ABORTED = 2;

  // ----------------------------------------------------------------------
  // Parameter sector layout
  // ----------------------------------------------------------------------
  localparam int         CTL_MASTER_BIT = 0;
  localparam int         CTL_MAX_BIT    = 8;
  localparam logic [7:0] WORD_CTL       = 8'h00;
  localparam logic [7:0] WORD_PW_FIRST  = 8'h01;
  localparam logic [7:0] WORD_PW_LAST   = 8'h10;
  localparam logic [7:0] WORD_REV_LO    = 8'h11;
  localparam logic [7:0] WORD_REV_HI    = 8'h12;
  localparam logic [7:0] WORD_LAST      = 8'hFF;
  localparam int         PW_BITS        = 256;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] REV_DEFAULT   = 16'hFFFE;
  localparam logic [7:0]  STATUS_RESET  = 8'h40;
  localparam logic [7:0]  ERROR_RESET   = 8'h00;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {PH_IDLE, PH_DECODE, PH_XFER, PH_APPLY} phase_e;

  typedef struct packed {
    logic               is_master;
    logic [PW_BITS-1:0] password;
  } pw_cmp_s;

endpackage : sec_lock_pkg

// *** sec_lock_core.sv ***
// Security freeze-lock and set-password command engine of the drive.
// Assumes opcodes, data words and reset events arrive on mclk_in from
// the drive's own task-file logic; nrst_in stands for power-on reset.
`timescale 1ns/1ps

// Overview of operation
// - Freeze-lock opcode enters frozen state at once, no data phase.
// - While frozen, set-password, unlock, disable and erase are rejected.
// - Frozen state lasts until power off; nothing else clears it.
// - Set-password stores master or user password per control word.
// - User password arms lock; locking follows next COMRESET with SSP disabled, or power-on.
// - Master-only password is recorded but never causes locking.
// - Set-password takes exactly one sector of host data.
// - Control bit 0 picks master/user; bit 8 picks maximum/high level.
// - Password is words 1 to 16; all 32 bytes count.
// - Revision code from word 17 only when master is selected.
// - Stored revision code is reported as identify word 92.
// - Revision code reads FFFEh until one has been written.
// - User/high: user or master password may unlock.
// - Master identifier stores master password without enabling lock.
// - User/maximum: master kept but refused; only user password unlocks.
// - At maximum level, erase sequence is the fallback unlock path.
module sec_lock_core (
  // Clock and reset
  input  wire logic                    mclk_in,
  input  wire logic                    nrst_in,
  input  wire logic                    nv_init_in,
  // Link reset from the interface
  input  wire logic                    comreset_in,
  input  wire logic                    ssp_disabled_in,
  // Command register
  input  wire logic                    cmd_valid_in,
  input  wire logic [7:0]              cmd_opcode_in,
  // Parameter data words
  input  wire logic                    data_valid_in,
  input  wire logic [15:0]             data_in,
  // Password comparison for unlock logic
  input  wire logic                    cmp_valid_in,
  input  wire sec_lock_pkg::pw_cmp_s   cmp_in,
  input  wire logic                    erase_done_in,
  // Task-file answers
  output logic [7:0]                   drive_condition_flags_out,
  output logic [7:0]                   fault_cause_flags_out,
  output logic [15:0]                  rev_code_out,
  // Security state
  output logic                         frozen_out,
  output logic                         lock_enabled_out,
  output logic                         locked_out,
  output logic                         max_level_out,
  output logic                         cmp_done_out,
  output logic                         cmp_match_out
);
  import sec_lock_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    phase_e             phase;
    logic               frozen;
    logic               lock_en;
    logic               locked;
    logic               max_lvl;
    logic               user_set;
    logic               master_set;
    logic [PW_BITS-1:0] user_pw;
    logic [PW_BITS-1:0] master_pw;
    logic [15:0]        rev;
    logic [15:0]        ctl;
    logic [PW_BITS-1:0] pw_buf;
    logic [15:0]        rev_buf;
    logic [7:0]         wcnt;
    logic [7:0]         status;
    logic [7:0]         error;
    logic               cmp_done;
    logic               cmp_match;
    logic [7:0]         pend_op;
  } state_s;

  state_s st;
  state_s next_st;

  // Builds a status byte from the three live conditions
  function automatic logic [7:0] status_byte(input logic busy,
                                             input logic xfer,
                                             input logic err);
    logic [7:0] b;
    b              = 8'h00;
    b[BIT_BUSY]    = busy;
    b[BIT_READY]   = ~busy;
    b[BIT_XFER]    = xfer;
    b[BIT_ERR]     = err;
    return b;
  endfunction : status_byte

  // Error byte with only the aborted cause
  function automatic logic [7:0] abort_byte(input logic aborted_command_flag);
    logic [7:0] b;
    b              = 8'h00;
    b[BIT_ABORTED] = aborted_command_flag;
    return b;
  endfunction : abort_byte

  logic cmd_take;
  logic is_guarded;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  assign cmd_take   = cmd_valid_in && (st.phase == PH_IDLE);
  assign is_guarded = (cmd_opcode_in == OP_SET_PASSWORD) ||
                      (cmd_opcode_in == OP_UNLOCK) ||
                      (cmd_opcode_in == OP_DISABLE_PW) ||
                      (cmd_opcode_in == OP_ERASE_UNIT);

  always_comb begin
    next_st          = st;
    next_st.cmp_done = 1'b0;
    if (!nrst_in) begin
      // Power-on: volatile state clears, stored lock state applies
      next_st.phase     = PH_IDLE;
      next_st.frozen    = 1'b0;
      next_st.locked    = nv_init_in ? 1'b0 : st.lock_en;
      next_st.ctl       = 16'h0000;
      next_st.pw_buf    = '0;
      next_st.rev_buf   = 16'h0000;
      next_st.wcnt      = 8'h00;
      next_st.status    = STATUS_RESET;
      next_st.error     = ERROR_RESET;
      next_st.cmp_match = 1'b0;
      next_st.pend_op   = 8'h00;
      if (nv_init_in) begin
        // Factory state of the media-held fields
        next_st.lock_en    = 1'b0;
        next_st.max_lvl    = 1'b0;
        next_st.user_set   = 1'b0;
        next_st.master_set = 1'b0;
        next_st.user_pw    = '0;
        next_st.master_pw  = '0;
        next_st.rev        = REV_DEFAULT;
      end
    end else if (comreset_in) begin
      // Link reset ends any command; frozen survives until power off
      next_st.phase  = PH_IDLE;
      next_st.wcnt   = 8'h00;
      next_st.status = status_byte(1'b0, 1'b0, 1'b0);
      next_st.error  = ERROR_RESET;
      if (ssp_disabled_in)
        next_st.locked = st.lock_en;
    end else begin
      // Erase done: lock released, master kept; a same-cycle set wins
      if (erase_done_in) begin
        next_st.lock_en  = 1'b0;
        next_st.locked   = 1'b0;
        next_st.user_set = 1'b0;
        next_st.max_lvl  = 1'b0;
      end
      case (st.phase)
        PH_IDLE: begin
          if (cmd_take) begin
            next_st.pend_op = cmd_opcode_in;
            next_st.phase   = PH_DECODE;
            next_st.status  = status_byte(1'b1, 1'b0, 1'b0);
            next_st.error   = ERROR_RESET;
          end
        end
        PH_DECODE: begin
          next_st.phase = PH_IDLE;
          if (st.pend_op == OP_FREEZE_LOCK) begin
            next_st.frozen = 1'b1;
            next_st.status = status_byte(1'b0, 1'b0, 1'b0);
          end else if (st.frozen) begin
            // Any command but freeze-lock while frozen: abort and drop busy
            next_st.status = status_byte(1'b0, 1'b0, 1'b1);
            next_st.error  = abort_byte(1'b1);
          end else if (st.pend_op == OP_SET_PASSWORD) begin
            next_st.phase  = PH_XFER;
            next_st.wcnt   = 8'h00;
            next_st.status = status_byte(1'b0, 1'b1, 1'b0);
          end else begin
            next_st.status = status_byte(1'b0, 1'b0, 1'b0);
          end
        end
        PH_XFER: begin
          if (data_valid_in) begin
            // One sector of 256 words steers the command
            if (st.wcnt == WORD_CTL)
              next_st.ctl = data_in;
            if (st.wcnt >= WORD_PW_FIRST && st.wcnt <= WORD_PW_LAST)
              next_st.pw_buf[{4'(st.wcnt - WORD_PW_FIRST), 4'h0} +: 16] =
                data_in;
            if (st.wcnt == WORD_REV_LO)
              next_st.rev_buf = data_in;
            next_st.wcnt = st.wcnt + 8'h01;
            if (st.wcnt == WORD_LAST) begin
              next_st.phase  = PH_APPLY;
              next_st.status = status_byte(1'b1, 1'b0, 1'b0);
            end
          end
        end
        PH_APPLY: begin
          next_st.phase  = PH_IDLE;
          next_st.status = status_byte(1'b0, 1'b0, 1'b0);
          if (st.ctl[CTL_MASTER_BIT]) begin
            // Master entry: store password and code, lock untouched
            next_st.master_pw  = st.pw_buf;
            next_st.master_set = 1'b1;
            next_st.rev        = st.rev_buf;
          end else begin
            // User entry: arm lock, stay unlocked until a reset
            next_st.user_pw  = st.pw_buf;
            next_st.user_set = 1'b1;
            next_st.lock_en  = 1'b1;
            next_st.max_lvl  = st.ctl[CTL_MAX_BIT];
          end
        end
        default: begin
          next_st.phase = PH_IDLE;
        end
      endcase
      // Full 32-byte comparison; master refused at maximum level
      if (cmp_valid_in) begin
        next_st.cmp_done  = 1'b1;
        next_st.cmp_match = cmp_in.is_master ?
          (st.master_set && !st.max_lvl &&
           cmp_in.password == st.master_pw) :
          (st.user_set && cmp_in.password == st.user_pw);
      end
    end
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    st <= next_st;
  end

  // Outputs straight from the state flip-flops
  assign drive_condition_flags_out = st.status;
  assign fault_cause_flags_out     = st.error;
  assign rev_code_out              = st.rev;
  assign frozen_out                = st.frozen;
  assign lock_enabled_out          = st.lock_en;
  assign locked_out                = st.locked;
  assign max_level_out             = st.max_lvl;
  assign cmp_done_out              = st.cmp_done;
  assign cmp_match_out             = st.cmp_match;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_freeze_now;
    @(posedge mclk_in) disable iff (!nrst_in)
      cmd_take && cmd_opcode_in == OP_FREEZE_LOCK && !comreset_in
      ##1 !comreset_in |=> frozen_out && !drive_condition_flags_out[BIT_XFER];
  endproperty
  a_freeze_now: assert property (p_freeze_now)
    else $error("freeze-lock did not freeze in two cycles");

  property p_frozen_abort;
    @(posedge mclk_in) disable iff (!nrst_in)
      cmd_take && is_guarded && st.frozen && !comreset_in
      ##1 !comreset_in |=> fault_cause_flags_out[BIT_ABORTED] &&
      drive_condition_flags_out[BIT_ERR] &&
      !drive_condition_flags_out[BIT_BUSY];
  endproperty
  a_frozen_abort: assert property (p_frozen_abort)
    else $error("guarded command while frozen was not aborted");

  property p_frozen_stays;
    @(posedge mclk_in) disable iff (!nrst_in)
      frozen_out |=> frozen_out;
  endproperty
  a_frozen_stays: assert property (p_frozen_stays)
    else $error("frozen state cleared without power off");

  property p_user_arms;
    @(posedge mclk_in) disable iff (!nrst_in)
      st.phase == PH_APPLY && !st.ctl[CTL_MASTER_BIT] && !comreset_in &&
      !erase_done_in |=> lock_enabled_out && locked_out == $past(locked_out);
  endproperty
  a_user_arms: assert property (p_user_arms)
    else $error("user password did not arm lock or locked at once");

  property p_master_no_lock;
    @(posedge mclk_in) disable iff (!nrst_in)
      st.phase == PH_APPLY && st.ctl[CTL_MASTER_BIT] && !erase_done_in &&
      !comreset_in |=> $stable(lock_enabled_out) &&
      rev_code_out == $past(st.rev_buf);
  endproperty
  a_master_no_lock: assert property (p_master_no_lock)
    else $error("master password changed lock or missed revision code");

  property p_rev_kept;
    @(posedge mclk_in) disable iff (!nrst_in)
      st.phase == PH_APPLY && !st.ctl[CTL_MASTER_BIT]
      |=> $stable(rev_code_out);
  endproperty
  a_rev_kept: assert property (p_rev_kept)
    else $error("user password altered revision code");

  property p_comreset_lock;
    @(posedge mclk_in) disable iff (!nrst_in)
      comreset_in && ssp_disabled_in |=> locked_out == $past(lock_enabled_out);
  endproperty
  a_comreset_lock: assert property (p_comreset_lock)
    else $error("COMRESET did not apply armed lock");

  property p_master_refused;
    @(posedge mclk_in) disable iff (!nrst_in)
      cmp_valid_in && cmp_in.is_master && max_level_out && !comreset_in
      |=> cmp_done_out && !cmp_match_out;
  endproperty
  a_master_refused: assert property (p_master_refused)
    else $error("master password accepted at maximum level");

  property p_one_sector;
    @(posedge mclk_in) disable iff (!nrst_in)
      st.phase == PH_XFER && data_valid_in && st.wcnt == WORD_LAST &&
      !comreset_in |=> drive_condition_flags_out[BIT_BUSY] &&
      !drive_condition_flags_out[BIT_XFER];
  endproperty
  a_one_sector: assert property (p_one_sector)
    else $error("transfer request not dropped after 256th word");

  property p_erase_release;
    @(posedge mclk_in) disable iff (!nrst_in)
      erase_done_in && st.phase != PH_APPLY && !comreset_in
      |=> !lock_enabled_out && !locked_out;
  endproperty
  a_erase_release: assert property (p_erase_release)
    else $error("erase sequence did not release the lock");

  property p_xfer_open;
    @(posedge mclk_in) disable iff (!nrst_in)
      cmd_take && cmd_opcode_in == OP_SET_PASSWORD && !st.frozen &&
      !comreset_in ##1 !comreset_in |=>
      drive_condition_flags_out[BIT_XFER] &&
      !drive_condition_flags_out[BIT_BUSY];
  endproperty
  a_xfer_open: assert property (p_xfer_open)
    else $error("set-password did not open its data phase");

endmodule : sec_lock_core

// *** host_model.sv ***
// Host controller model: command strobes and one parameter sector.
// Assumes the bench polls status between calls; drives on falling edge.
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic        mclk_in,
  // Command and data toward the drive
  output logic             cmd_valid_out,
  output logic [7:0]       cmd_opcode_out,
  output logic             data_valid_out,
  output logic [15:0]      data_out
);
  // Idle levels at time zero
  initial begin
    cmd_valid_out  = 1'b0;
    cmd_opcode_out = 8'h00;
    data_valid_out = 1'b0;
    data_out       = 16'h0000;
  end

  // One-cycle command strobe; opcode garbled once released
  task automatic command(input logic [7:0] op);
    @(negedge mclk_in);
    cmd_valid_out  = 1'b1;
    cmd_opcode_out = op;
    @(negedge mclk_in);
    cmd_valid_out  = 1'b0;
    cmd_opcode_out = ~op;
  endtask : command

  // Exactly 256 words, one per cycle, then the bus is garbled
  task automatic sector(input logic [15:0] ctl, input logic [255:0] pw,
                        input logic [15:0] rev);
    for (int i = 0; i < 256; i++) begin
      @(negedge mclk_in);
      data_valid_out = 1'b1;
      if (i == 0) data_out = ctl;
      else if (i <= 16) data_out = pw[(i-1)*16 +: 16];
      else if (i == 17) data_out = rev; // Codes kept in 0001h..FFFEh
      else data_out = i[15:0];
    end
    @(negedge mclk_in);
    data_valid_out = 1'b0;
    data_out       = ~data_out;
  endtask : sector
endmodule : host_model

// *** testbench.sv ***
// Self-checking bench for the security freeze and set-password engine.
// Assumes host_model issues commands and sector data; the bench drives all other inputs.
`timescale 1ns/1ps
module testbench;
  import sec_lock_pkg::*;
  logic           mclk_in, nrst_in, nv_init_in, comreset_in, ssp_in;
  logic           cmd_valid, data_valid, cmp_valid, erase_done;
  logic [7:0]     cmd_opcode, status, error;
  logic [15:0]    data_word, rev_code;
  pw_cmp_s        cmp;
  logic           frozen, lock_en, locked, max_lvl, cmp_done, cmp_match;
  logic [255:0]   pw_u, pw_m;
  logic [7:0]     ops [4];
  int             fail_count, checked;

  sec_lock_core dut (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .nv_init_in(nv_init_in), .comreset_in(comreset_in),
    .ssp_disabled_in(ssp_in), .cmd_valid_in(cmd_valid),
    .cmd_opcode_in(cmd_opcode), .data_valid_in(data_valid),
    .data_in(data_word), .cmp_valid_in(cmp_valid), .cmp_in(cmp),
    .erase_done_in(erase_done), .drive_condition_flags_out(status),
    .fault_cause_flags_out(error), .rev_code_out(rev_code),
    .frozen_out(frozen), .lock_enabled_out(lock_en),
    .locked_out(locked), .max_level_out(max_lvl),
    .cmp_done_out(cmp_done), .cmp_match_out(cmp_match));

  host_model host (.mclk_in(mclk_in), .cmd_valid_out(cmd_valid),
    .cmd_opcode_out(cmd_opcode), .data_valid_out(data_valid),
    .data_out(data_word));

  // 125 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic conclude;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkb(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask : chkb

  // Bounded wait until busy drops
  task automatic wait_free;
    int n;
    n = 0;
    @(negedge mclk_in);
    while (status[BIT_BUSY] !== 1'b0) begin
      @(negedge mclk_in);
      n++;
      if (n > 50) begin
        fail_count++;
        $display("ERROR %0t busy never dropped", $time);
        conclude();
      end
    end
  endtask : wait_free

  task automatic set_pw(input logic [15:0] ctl, input logic [255:0] pw,
                        input logic [15:0] rev);
    host.command(OP_SET_PASSWORD);
    wait_free();
    chk({8'h00, status}, 16'h0048); // Data phase opens
    host.sector(ctl, pw, rev);
    wait_free();
    chk({8'h00, status}, 16'h0040);
  endtask : set_pw

  // Compare request; answer checked one cycle later
  task automatic compare(input logic m, input logic [255:0] pw,
                         input logic exp);
    @(negedge mclk_in);
    cmp_valid = 1'b1;
    cmp       = '{is_master: m, password: pw};
    @(negedge mclk_in);
    chkb(cmp_done, 1'b1);
    chkb(cmp_match, exp);
    cmp_valid = 1'b0;
    cmp       = ~cmp;
  endtask : compare

  task automatic por(input logic nv);
    @(negedge mclk_in);
    nrst_in    = 1'b0;
    nv_init_in = nv;
    repeat (8) @(negedge mclk_in);
    nrst_in    = 1'b1;
    nv_init_in = ~nv;
  endtask : por

  task automatic link_reset(input logic ssp);
    @(negedge mclk_in);
    comreset_in = 1'b1;
    ssp_in      = ssp;
    @(negedge mclk_in);
    comreset_in = 1'b0;
    ssp_in      = ~ssp;
  endtask : link_reset

  task automatic erase;
    @(negedge mclk_in);
    erase_done = 1'b1;
    @(negedge mclk_in);
    erase_done = 1'b0;
  endtask : erase

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    fail_count  = 0;
    checked     = 0;
    nrst_in     = 1'b0;
    nv_init_in  = 1'b1;
    comreset_in = 1'b0;
    ssp_in      = 1'b0;
    cmp_valid   = 1'b0;
    erase_done  = 1'b0;
    cmp         = '0;
    pw_m        = {16{16'hA5C3}};
    pw_u        = {8{32'h1234ABCD}};
    ops         = '{OP_SET_PASSWORD, OP_UNLOCK, OP_DISABLE_PW, OP_ERASE_UNIT};
    por(1'b1);
    chk({8'h00, status}, 16'h0040);
    chk({8'h00, error}, 16'h0000);
    chk(rev_code, REV_DEFAULT);
    // Master password at both levels: code kept, no lock
    set_pw(16'h0001, pw_m ^ 256'h1, 16'h0001);
    chk(rev_code, 16'h0001);
    set_pw(16'h0101, pw_m, 16'hFFFD);
    chk(rev_code, 16'hFFFD);
    chkb(lock_en, 1'b0);
    por(1'b0);
    chkb(locked, 1'b0);
    // User password at high level
    set_pw(16'h0000, pw_u, 16'h0BAD);
    chk(rev_code, 16'hFFFD);
    chkb(lock_en, 1'b1);
    chkb(locked, 1'b0);
    chkb(max_lvl, 1'b0);
    compare(1'b1, pw_m, 1'b1);
    compare(1'b0, pw_u, 1'b1);
    compare(1'b0, pw_u ^ {1'b1, 255'h0}, 1'b0);
    compare(1'b1, pw_m ^ 256'h1, 1'b0);
    link_reset(1'b0);
    chkb(locked, 1'b0);
    link_reset(1'b1);
    chkb(locked, 1'b1);
    erase();
    chkb(locked, 1'b0);
    chkb(lock_en, 1'b0);
    // User password at maximum level, then power cycle
    set_pw(16'h0100, pw_u, 16'h0002);
    chkb(max_lvl, 1'b1);
    por(1'b0);
    chkb(locked, 1'b1);
    compare(1'b1, pw_m, 1'b0);
    compare(1'b0, pw_u, 1'b1);
    erase();
    chkb(locked, 1'b0);
    // Guarded opcode while not frozen completes without abort
    host.command(OP_UNLOCK);
    wait_free();
    chk({8'h00, status}, 16'h0040);
    chk({8'h00, error}, 16'h0000);
    // Freeze, then guarded commands before and after a link reset
    host.command(OP_FREEZE_LOCK);
    wait_free();
    chk({8'h00, status}, 16'h0040); // No data phase
    chkb(frozen, 1'b1);
    for (int p = 0; p < 2; p++) begin
      foreach (ops[i]) begin
        host.command(ops[i]);
        wait_free();
        chk({8'h00, status}, 16'h0041);
        chk({8'h00, error}, 16'h0004);
      end
      link_reset(1'b1);
      chkb(frozen, 1'b1);
    end
    por(1'b0);
    chkb(frozen, 1'b0);
    conclude();
  end
endmodule : testbench
